// File: hdl/reftl_core.sv
// restricted earth-fault trip core with axi4-lite register access
//
// Chosen here: the AXI4-Lite register port and the address map.
module reftl_core #(
  parameter int PH_W = reftl_pkg::PH_W_DEF
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write channels
  input wire logic [reftl_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read channels
  input wire logic [reftl_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // compensated phasors from upstream
  input wire logic signed [PH_W-1:0] phase_a_re,
  input wire logic signed [PH_W-1:0] phase_a_im,
  input wire logic signed [PH_W-1:0] phase_b_re,
  input wire logic signed [PH_W-1:0] phase_b_im,
  input wire logic signed [PH_W-1:0] phase_c_re,
  input wire logic signed [PH_W-1:0] phase_c_im,
  input wire logic signed [PH_W-1:0] neutral_re,
  input wire logic signed [PH_W-1:0] neutral_im,
  input wire logic phasor_valid,
  output logic phasor_ready,
  // user logic inputs
  input wire logic sens_boost_in,
  input wire logic user_block_in,
  // status and measured values
  output logic general_trip_out,
  output logic dir_start_flag,
  output logic char_trip_internal,
  output logic [PH_W+2:0] diff_current_meas,
  output logic [PH_W+2:0] bias_current_meas,
  output logic irq
);
  import reftl_pkg::*;
  localparam int CW = PH_W + 2;
  localparam int MW = PH_W + 3;
  localparam int SW = 2 * MW;

  if (PH_W < 8 || PH_W > 24) begin : g_bad_w
    $error("reftl_core: PH_W must lie in 8..24");
  end

  function automatic logic signed [CW-1:0] ext(input logic signed [PH_W-1:0] v);
    return CW'(v);
  endfunction

  function automatic logic [SW-1:0] mag_sq(input logic signed [CW-1:0] re,
                                           input logic signed [CW-1:0] im);
    logic signed [2*CW-1:0] pr;
    logic signed [2*CW-1:0] pi;
    pr = re * re;
    pi = im * im;
    return SW'(unsigned'(pr)) + SW'(unsigned'(pi));
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction

  reftl_state_t state_r;
  logic [2:0] idx_r;
  logic signed [CW-1:0] cap_re_r [N_MAG];
  logic signed [CW-1:0] cap_im_r [N_MAG];
  logic signed [CW-1:0] in_re [N_MAG];
  logic signed [CW-1:0] in_im [N_MAG];
  logic [MW-1:0] mag_r [N_MAG];
  logic signed [2*CW:0] dot;
  logic dir_pend_r, dir_r, char_r, trip_r, boost_r;
  logic [MW-1:0] diff_r, bias_r, bias_max;
  logic sq_done, char_above, blocked;
  logic [MW-1:0] sq_root;
  logic en_r, dchk_r;
  logic [7:0] base_r, slope_r, knee_r;
  logic [IRQ_W-1:0] irqs_r, irqm_r, ev;
  logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
  logic [ADDR_W-1:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r, rd_data, set_old, set_new;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic wr_go, rd_ok, wr_map, set_ok;

  // zero-sequence sum and the four-phasor differential sum
  always_comb begin
    in_re[0] = ext(phase_a_re);
    in_im[0] = ext(phase_a_im);
    in_re[1] = ext(phase_b_re);
    in_im[1] = ext(phase_b_im);
    in_re[2] = ext(phase_c_re);
    in_im[2] = ext(phase_c_im);
    in_re[3] = ext(neutral_re);
    in_im[3] = ext(neutral_im);
    in_re[4] = in_re[0] + in_re[1] + in_re[2] + in_re[3];
    in_im[4] = in_im[0] + in_im[1] + in_im[2] + in_im[3];
    // negative dot product means the angle is beyond +-90 deg
    dot = (2*CW+1)'((in_re[0] + in_re[1] + in_re[2]) * in_re[3])
        + (2*CW+1)'((in_im[0] + in_im[1] + in_im[2]) * in_im[3]);
  end

  assign phasor_ready = (state_r == ST_IDLE);

  // evaluation sequencer, one shared square-root unit for all magnitudes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= ST_IDLE;
      idx_r <= 3'h0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          idx_r <= 3'h0;
          if (phasor_valid) begin
            state_r <= ST_CALC;
          end
        end
        ST_CALC: state_r <= ST_WAIT;
        ST_WAIT: begin
          if (sq_done) begin
            if (idx_r == 3'(N_MAG - 1)) begin
              state_r <= ST_EVAL;
            end else begin
              idx_r <= idx_r + 3'h1;
              state_r <= ST_CALC;
            end
          end
        end
        ST_EVAL: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // phasor capture on the accepted strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N_MAG; i++) begin
        cap_re_r[i] <= '0;
        cap_im_r[i] <= '0;
      end
      dir_pend_r <= 1'b0;
      boost_r <= 1'b0;
    end else if (phasor_valid && phasor_ready) begin
      cap_re_r <= in_re;
      cap_im_r <= in_im;
      dir_pend_r <= dot[2*CW];
      boost_r <= sens_boost_in;
    end
  end

  // magnitudes collected as the root unit finishes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < N_MAG; i++) begin
        mag_r[i] <= '0;
      end
    end else if (state_r == ST_WAIT && sq_done) begin
      mag_r[idx_r] <= sq_root;
    end
  end

  reftl_isqrt #(
    .IW(SW)
  ) u_isqrt (
    .aclk(aclk),
    .aresetn(aresetn),
    .start(state_r == ST_CALC),
    .radicand(mag_sq(cap_re_r[idx_r], cap_im_r[idx_r])),
    .done(sq_done),
    .root(sq_root)
  );

  // restraint is the largest of the phase and neutral magnitudes
  always_comb begin
    bias_max = mag_r[0];
    for (int i = 1; i < N_MAG - 1; i++) begin
      if (mag_r[i] > bias_max) begin
        bias_max = mag_r[i];
      end
    end
  end

  reftl_char #(
    .MW(MW)
  ) u_char (
    .diff_mag(mag_r[4]),
    .bias_mag(bias_max),
    .base_pct(base_r),
    .slope_pct(slope_r),
    .knee_pct(knee_r),
    .boost(boost_r),
    .above(char_above)
  );

  // results published together at the end of an evaluation
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diff_r <= '0;
      bias_r <= '0;
      char_r <= 1'b0;
      dir_r <= 1'b0;
    end else if (state_r == ST_EVAL) begin
      diff_r <= mag_r[4];
      bias_r <= bias_max;
      char_r <= char_above;
      dir_r <= dir_pend_r;
    end
  end

  // block and enable act every cycle so a block input bites at the next clock
  assign blocked = (dir_r && dchk_r) || user_block_in;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trip_r <= 1'b0;
    end else begin
      trip_r <= char_r && !blocked && en_r;
    end
  end

  assign general_trip_out = trip_r;
  assign dir_start_flag = dir_r;
  assign char_trip_internal = char_r;
  assign diff_current_meas = diff_r;
  assign bias_current_meas = bias_r;

  // axi write: address and data taken in either order, one at a time
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign wr_go = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_map = hit(aw_addr_r, OFS_CTRL) || hit(aw_addr_r, OFS_SET) ||
                  hit(aw_addr_r, OFS_STAT) || hit(aw_addr_r, OFS_DIFF) ||
                  hit(aw_addr_r, OFS_BIAS) || hit(aw_addr_r, OFS_IRQS) ||
                  hit(aw_addr_r, OFS_IRQM);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_data_r <= '0;
      w_strb_r <= '0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_map ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // operation and direction-check switches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_r <= CTRL_EN_RST;
      dchk_r <= CTRL_DIR_RST;
    end else if (wr_go && hit(aw_addr_r, OFS_CTRL) && w_strb_r[0]) begin
      en_r <= w_data_r[CTRL_EN_BIT];
      dchk_r <= w_data_r[CTRL_DIR_BIT];
    end
  end

  // settings are all-or-nothing: one bad field rejects the whole write
  assign set_old = {8'h00, knee_r, slope_r, base_r};
  assign set_new = merge(set_old, w_data_r, w_strb_r);
  assign set_ok = set_new[SET_BASE_LSB +: 8] >= BASE_MIN &&
                  set_new[SET_BASE_LSB +: 8] <= BASE_MAX &&
                  set_new[SET_SLOPE_LSB +: 8] >= SLOPE_MIN &&
                  set_new[SET_SLOPE_LSB +: 8] <= SLOPE_MAX &&
                  set_new[SET_KNEE_LSB +: 8] >= KNEE_MIN && set_new[SET_KNEE_LSB +: 8] <= KNEE_MAX;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      base_r <= BASE_RST;
      slope_r <= SLOPE_RST;
      knee_r <= KNEE_RST;
    end else if (wr_go && hit(aw_addr_r, OFS_SET) && set_ok) begin
      base_r <= set_new[SET_BASE_LSB +: 8];
      slope_r <= set_new[SET_SLOPE_LSB +: 8];
      knee_r <= set_new[SET_KNEE_LSB +: 8];
    end
  end

  // interrupt events; a set in the clearing cycle wins
  always_comb begin
    ev = '0;
    ev[IRQ_TRIP] = (char_r && !blocked && en_r) && !trip_r;
    ev[IRQ_DIR] = (state_r == ST_EVAL) && dir_pend_r && !dir_r;
    ev[IRQ_MEAS] = (state_r == ST_EVAL);
    ev[IRQ_SETERR] = wr_go && hit(aw_addr_r, OFS_SET) && !set_ok;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irqs_r <= '0;
      irqm_r <= IRQ_MASK_RST;
    end else begin
      if (wr_go && hit(aw_addr_r, OFS_IRQS) && w_strb_r[0]) begin
        irqs_r <= (irqs_r & ~w_data_r[IRQ_W-1:0]) | ev;
      end else begin
        irqs_r <= irqs_r | ev;
      end
      if (wr_go && hit(aw_addr_r, OFS_IRQM) && w_strb_r[0]) begin
        irqm_r <= w_data_r[IRQ_W-1:0];
      end
    end
  end
  assign irq = |(irqs_r & irqm_r);

  // read decode; unmapped addresses answer slverr with zero data
  always_comb begin
    rd_data = '0;
    rd_ok = 1'b1;
    if (hit(s_axi_araddr, OFS_CTRL)) begin
      rd_data[CTRL_EN_BIT] = en_r;
      rd_data[CTRL_DIR_BIT] = dchk_r;
    end else if (hit(s_axi_araddr, OFS_SET)) begin
      rd_data = set_old;
    end else if (hit(s_axi_araddr, OFS_STAT)) begin
      rd_data[ST_TRIP_BIT] = trip_r;
      rd_data[ST_DIR_BIT] = dir_r;
      rd_data[ST_CHAR_BIT] = char_r;
      rd_data[ST_BUSY_BIT] = !phasor_ready;
    end else if (hit(s_axi_araddr, OFS_DIFF)) begin
      rd_data = 32'(diff_r);
    end else if (hit(s_axi_araddr, OFS_BIAS)) begin
      rd_data = 32'(bias_r);
    end else if (hit(s_axi_araddr, OFS_IRQS)) begin
      rd_data = 32'(irqs_r);
    end else if (hit(s_axi_araddr, OFS_IRQM)) begin
      rd_data = 32'(irqm_r);
    end else begin
      rd_ok = 1'b0;
    end
  end

  assign s_axi_arready = !rvalid_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_data;
      rresp_r <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule

// File: hdl/reftl_pkg.sv
// constants, offsets and types shared by the earth-fault trip core
package reftl_pkg;
  // phasor component width and percent scaling
  localparam int PH_W_DEF = 16;
  localparam int FRAC_BITS = 4;
  localparam int PCT_SCALE = 100;
  localparam int BOOST_SHIFT = 2;
  localparam int N_MAG = 5;
  localparam int ADDR_W = 8;

  // register byte offsets
  localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_SET = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_STAT = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DIFF = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_BIAS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQS = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_IRQM = 8'h18;

  // control field positions and reset values
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_DIR_BIT = 1;
  localparam logic CTRL_EN_RST = 1'b1;
  localparam logic CTRL_DIR_RST = 1'b1;

  // setting field positions, ranges and reset values
  localparam int SET_BASE_LSB = 0;
  localparam int SET_SLOPE_LSB = 8;
  localparam int SET_KNEE_LSB = 16;
  localparam logic [7:0] BASE_MIN = 8'h0a;
  localparam logic [7:0] BASE_MAX = 8'h32;
  localparam logic [7:0] BASE_RST = 8'h1e;
  localparam logic [7:0] SLOPE_MIN = 8'h32;
  localparam logic [7:0] SLOPE_MAX = 8'h64;
  localparam logic [7:0] SLOPE_RST = 8'h46;
  localparam logic [7:0] KNEE_MIN = 8'h64;
  localparam logic [7:0] KNEE_MAX = 8'hc8;
  localparam logic [7:0] KNEE_RST = 8'h7d;

  // status and interrupt bit positions
  localparam int ST_TRIP_BIT = 0;
  localparam int ST_DIR_BIT = 1;
  localparam int ST_CHAR_BIT = 2;
  localparam int ST_BUSY_BIT = 3;
  localparam int IRQ_W = 4;
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_DIR = 1;
  localparam int IRQ_MEAS = 2;
  localparam int IRQ_SETERR = 3;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 4'h0;

  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {ST_IDLE, ST_CALC, ST_WAIT, ST_EVAL} reftl_state_t;
endpackage

// File: hdl/reftl_isqrt.sv
// sequential integer square root, one result bit per clock
module reftl_isqrt #(
  parameter int IW = 38
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // request
  input wire logic start,
  input wire logic [IW-1:0] radicand,
  // result
  output logic done,
  output logic [IW/2-1:0] root
);
  if (IW < 4 || IW % 2 != 0) begin : g_bad_iw
    $error("reftl_isqrt: IW must be even and at least 4");
  end

  logic [IW-1:0] op_r;
  logic [IW-1:0] res_r;
  logic [IW-1:0] one_r;
  logic busy_r;
  logic done_r;
  logic [IW-1:0] trial;

  assign trial = res_r + one_r;

  // restoring digit loop; start restarts even when busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      op_r <= '0;
      res_r <= '0;
      one_r <= '0;
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (start) begin
        op_r <= radicand;
        res_r <= '0;
        one_r <= {2'b01, {(IW-2){1'b0}}};
        busy_r <= 1'b1;
      end else if (busy_r) begin
        if (one_r == '0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          if (op_r >= trial) begin
            op_r <= op_r - trial;
            res_r <= (res_r >> 1) + one_r;
          end else begin
            res_r <= res_r >> 1;
          end
          one_r <= one_r >> 2;
        end
      end
    end
  end

  assign done = done_r;
  assign root = res_r[IW/2-1:0];
endmodule

// File: hdl/reftl_char.sv
// two-section percentage differential characteristic comparator
module reftl_char #(
  parameter int MW = 19
) (
  // magnitudes, percent with fraction bits
  input wire logic [MW-1:0] diff_mag,
  input wire logic [MW-1:0] bias_mag,
  // settings in whole percent
  input wire logic [7:0] base_pct,
  input wire logic [7:0] slope_pct,
  input wire logic [7:0] knee_pct,
  input wire logic boost,
  // result
  output logic above
);
  import reftl_pkg::*;
  localparam int XW = MW + 24;

  logic [XW-1:0] lhs;
  logic [XW-1:0] base_term;
  logic [XW-1:0] knee_fix;
  logic [XW-1:0] over;
  logic [XW-1:0] rhs;

  // everything scaled by 100 so the slope needs no divider
  always_comb begin
    lhs = XW'(diff_mag) * XW'(PCT_SCALE);
    base_term = (XW'(base_pct) * XW'(PCT_SCALE)) << FRAC_BITS;
    if (boost) begin
      base_term = base_term >> BOOST_SHIFT;
    end
    knee_fix = XW'(knee_pct) << FRAC_BITS;
    // flat up to the knee, then slope times restraint above the knee
    over = (XW'(bias_mag) > knee_fix) ? XW'(bias_mag) - knee_fix : '0;
    rhs = base_term + XW'(slope_pct) * over;
    above = lhs > rhs;
  end
endmodule

// File: tb/reftl_core_checker.sv
// concurrent checks on the earth-fault trip core ports
module reftl_core_checker #(
  parameter int PH_W = 16
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // bus handshakes
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // phasor path and results
  input wire logic phasor_valid,
  input wire logic phasor_ready,
  input wire logic user_block_in,
  input wire logic general_trip_out,
  input wire logic dir_start_flag,
  input wire logic char_trip_internal,
  input wire logic [PH_W+2:0] diff_current_meas
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // trip only follows a characteristic trip of the cycle before
  AST_TRIP_NEEDS_CHAR: assert property (
    general_trip_out |-> $past(char_trip_internal)) else $error("trip without char trip");
  AST_USER_BLOCK: assert property (
    user_block_in |=> !general_trip_out) else $error("trip despite user block");
  // results may only move as an evaluation ends, never while idle
  AST_RESULT_ON_EVAL: assert property (
    ($changed(dir_start_flag) || $changed(char_trip_internal) || $changed(diff_current_meas))
    |-> !$past(phasor_ready)) else $error("results changed outside evaluation");
  AST_BUSY_AFTER_TAKE: assert property (
    phasor_valid && phasor_ready |=> !phasor_ready [*8]) else $error("ready too early");
  AST_EVAL_BOUNDED: assert property (
    phasor_valid && phasor_ready |=> ##[1:400] phasor_ready) else $error("evaluation hung");
  // bus answers come and stand until taken
  AST_WRITE_ANSWER: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("no write response");
  AST_BRESP_HOLD: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_READ_ANSWER: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("no read data");
  AST_RDATA_HOLD: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  CVR_TRIP: cover property ($rose(general_trip_out));
  CVR_DIR: cover property ($rose(dir_start_flag));
  CVR_BLOCKED: cover property (char_trip_internal && user_block_in);
endmodule

bind reftl_core reftl_core_checker #(.PH_W(PH_W)) reftl_core_checker_inst (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .phasor_valid(phasor_valid),
  .phasor_ready(phasor_ready), .user_block_in(user_block_in),
  .general_trip_out(general_trip_out), .dir_start_flag(dir_start_flag),
  .char_trip_internal(char_trip_internal), .diff_current_meas(diff_current_meas)
);

// File: tb/reftl_up_model.sv
// upstream phasor stage model presenting compensated phasor sets
module reftl_up_model #(
  parameter int PH_W = 16
) (
  // clock
  input wire logic aclk,
  // phasor handshake
  input wire logic phasor_ready,
  output logic phasor_valid,
  output logic [8*PH_W-1:0] ph
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    phasor_valid = 1'b0;
    ph = '0;
  end
  // idle lines toggle so a stale set never looks like a fresh one
  task automatic send(input logic [8*PH_W-1:0] v, input int stall, output bit ok);
    int n;
    n = 0;
    repeat (stall) begin
      ph <= ~ph;
      @(posedge aclk);
    end
    ph <= v;
    phasor_valid <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
    end while (!phasor_ready && n < 1000);
    ok = phasor_ready;
    phasor_valid <= 1'b0;
    ph <= ~v;
  endtask
endmodule

// File: tb/tb_reftl_core.sv
// self-checking bench for the earth-fault trip core
module tb_reftl_core;
  timeunit 1ns;
  timeprecision 1ps;
  import reftl_pkg::*;
  localparam int PW = 16;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, pvalid, pready, boost, blk, trip, irq, ok;
  logic [7:0] awaddr, araddr, base, slope, knee;
  logic [31:0] wdata, rdata, seed, r, st;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [8*PW-1:0] ph, v;
  logic [PW+2:0] dmeas, bmeas;
  logic [24:0] tbl[8];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  logic en, dc, cflag, dflag;
  longint d, bi;
  int fails, checks, c[8], n;

  reftl_core #(.PH_W(PW)) reftl_core_inst (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .phase_a_re(ph[0+:PW]), .phase_a_im(ph[PW+:PW]), .phase_b_re(ph[2*PW+:PW]),
    .phase_b_im(ph[3*PW+:PW]), .phase_c_re(ph[4*PW+:PW]), .phase_c_im(ph[5*PW+:PW]),
    .neutral_re(ph[6*PW+:PW]), .neutral_im(ph[7*PW+:PW]), .phasor_valid(pvalid),
    .phasor_ready(pready), .sens_boost_in(boost), .user_block_in(blk),
    .general_trip_out(trip), .dir_start_flag(dflag), .char_trip_internal(cflag),
    .diff_current_meas(dmeas), .bias_current_meas(bmeas), .irq(irq));
  reftl_up_model #(.PH_W(PW)) reftl_up_model_inst (.aclk(aclk), .phasor_ready(pready),
    .phasor_valid(pvalid), .ph(ph));

  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  task automatic check(input logic [33:0] got, input logic [33:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (fails == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic hang();
    fails++;
    stop_test();
  endtask

  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // floor square root by bit trial, wide enough for any summed phasor
  function automatic longint isq(input longint x);
    longint q, t;
    q = 0;
    for (int b = 20; b >= 0; b--) begin
      t = q + (longint'(1) << b);
      if (t * t <= x) q = t;
    end
    return q;
  endfunction

  // expected status word and measured values from the present set
  task automatic eval();
    longint m, zr, zi, thr;
    logic dir, ch;
    zr = c[0] + c[2] + c[4];
    zi = c[1] + c[3] + c[5];
    d = isq((zr + c[6]) ** 2 + (zi + c[7]) ** 2);
    bi = 0;
    for (int k = 0; k < 4; k++) begin
      m = isq(c[2*k] * c[2*k] + c[2*k+1] * c[2*k+1]);
      if (m > bi) bi = m;
    end
    dir = (zr * c[6] + zi * c[7]) < 0;
    thr = longint'(base) * 1600 / (boost ? 4 : 1);
    if (bi > longint'(knee) * 16) thr += longint'(slope) * (bi - longint'(knee) * 16);
    ch = d * 100 > thr;
    st = {29'h0, ch, dir, ch && en && !((dir && dc) || blk)};
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] dd, input logic [3:0] s,
                    input logic [1:0] rs);
    int k;
    bq.push_back(rs);
    awaddr <= a;
    wdata <= dd;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 100);
    if (k >= 100) hang();
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] dd, input logic [1:0] rs);
    int k;
    rq.push_back({rs, dd});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    k = 0;
    do begin
      @(posedge aclk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 100);
    if (k >= 100) hang();
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // trip and interrupt ports looked at mid-cycle, once settled
  task automatic pchk(input logic [1:0] e);
    @(negedge aclk);
    check(34'({trip, irq}), 34'(e));
    @(posedge aclk);
  endtask

  // every bus answer is compared with the oldest note
  always @(posedge aclk) begin
    if (rvalid && rready && rq.size() > 0) check({rresp, rdata}, rq.pop_front());
    if (bvalid && bready && bq.size() > 0) check(34'(bresp), 34'(bq.pop_front()));
  end

  initial begin
    {seed, fails, checks} = {32'h64f04e03, 64'h0};
    {aresetn, awvalid, wvalid, bready, arvalid, rready, boost, blk} = 8'h0;
    {awaddr, araddr, wdata, wstrb} = '0;
    {base, slope, knee, en, dc} = {8'h1e, 8'h46, 8'h7d, 2'h3};
    tbl = '{25'h1c8640a, 25'h0c86409, 25'h0c86433, 25'h0c86532, 25'h0643132, 25'h0c96432,
            25'h0636432, 25'h1643232};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL, 32'h3, RESP_OKAY);
    rd(OFS_SET, 32'h007d461e, RESP_OKAY);
    rd(OFS_STAT, 32'h0, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_SLVERR);
    wr(8'h1c, 32'h0, 4'hf, RESP_SLVERR);
    wr(OFS_DIFF, 32'hffff, 4'hf, RESP_OKAY);
    rd(OFS_DIFF, 32'h0, RESP_OKAY);
    // range edges: out-of-range sets are dropped whole
    for (int i = 0; i < 8; i++) begin
      wr(OFS_SET, {8'h0, tbl[i][23:0]}, 4'hf, RESP_OKAY);
      if (tbl[i][24]) {knee, slope, base} = tbl[i][23:0];
      rd(OFS_SET, {8'h0, knee, slope, base}, RESP_OKAY);
    end
    rd(OFS_IRQS, 32'h8, RESP_OKAY);
    pchk(2'b00);
    wr(OFS_IRQM, 32'h8, 4'h1, RESP_OKAY);
    pchk(2'b01);
    wr(OFS_IRQS, 32'h8, 4'h1, RESP_OKAY);
    pchk(2'b00);
    wr(OFS_IRQM, 32'h4, 4'h1, RESP_OKAY);
    // random sets, settings and user inputs
    for (int i = 0; i < 24; i++) begin
      r = xs();
      if (i % 4 == 0) begin
        {base, slope, knee} = {8'(10 + r % 41), 8'(50 + r % 51), 8'(100 + r % 101)};
        {en, dc} = {r[0] | r[1], r[2]};
        wr(OFS_SET, {8'h0, knee, slope, base}, 4'hf, RESP_OKAY);
        wr(OFS_CTRL, {30'h0, dc, en}, 4'h1, RESP_OKAY);
      end
      boost <= r[3];
      blk <= (r[5:4] == 2'h0);
      for (int k = 0; k < 8; k++) begin
        c[k] = (k < 6) ? int'(xs() % 1024) - 512 : int'(xs() % 8192) - 4096;
        v[k*PW+:PW] = PW'(c[k]);
      end
      reftl_up_model_inst.send(v, 1 + int'(xs() % 3), ok);
      if (!ok) hang();
      n = 0;
      do begin
        @(posedge aclk);
        n++;
      end while (!pready && n < 400);
      if (n >= 400) hang();
      eval();
      check(34'({cflag, dflag, dmeas}), 34'({st[2:1], 19'(d)}));
      check(34'(bmeas), 34'(bi));
      rd(OFS_STAT, st, RESP_OKAY);
      rd(OFS_DIFF, 32'(d), RESP_OKAY);
      rd(OFS_BIAS, 32'(bi), RESP_OKAY);
      pchk({st[0], 1'b1});
      wr(OFS_IRQS, 32'hf, 4'h1, RESP_OKAY);
      if (st[0]) begin
        blk <= 1'b1;
        @(posedge aclk);
        pchk(2'b00);
      end
    end
    stop_test();
  end
endmodule
